// File: afe_slot_cfg_regs.svh
// Register offsets, field positions and reset values of the front-end slot
// configuration bank. Included by the register module only.
`ifndef AFE_SLOT_CFG_REGS_SVH
`define AFE_SLOT_CFG_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (8-bit register address space)
// ----------------------------------------------------------------------------
`define OFS_SLOT_A_ORDER 8'h17
`define OFS_SLOT_B_ORDER 8'h1d
`define OFS_SLOT_A_TIMING 8'h39
`define OFS_SLOT_B_TIMING 8'h3b
`define OFS_SLOT_A_FE_CTRL 8'h42
`define OFS_SLOT_A_PATH 8'h43
`define OFS_SLOT_B_FE_CTRL 8'h44
`define OFS_CHAN_GAIN 8'h55

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_ORDER 16'h0000
`define RST_SLOT_A_TIMING 16'h22fc
`define RST_SLOT_B_TIMING 16'h2017
`define RST_FE_CTRL 16'h1c38
`define RST_PATH 16'hada5
`define RST_CHAN_GAIN 16'h0000
`define RST_PULSE_IDX 2'h0
`define RST_REF_SELECT 2'h3
`define RST_SLOT_A_OFFSET 11'h2fc

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ORDER_MSB 3
`define WIDTH_MSB 15
`define WIDTH_LSB 11
`define OFFSET_MSB 10
`define BUF_BIT 7
`define IND_EN_BIT 6
`define VREF_MSB 5
`define VREF_LSB 4
`define GAIN_MSB 1
`define CH2_GAIN_MSB 1
`define CH3_GAIN_LSB 2
`define CH3_GAIN_MSB 3
`define CH4_GAIN_LSB 4
`define CH4_GAIN_MSB 5

// ----------------------------------------------------------------------------
// Path connection codes
// ----------------------------------------------------------------------------
`define PATH_FULL_ANALOG 16'hada5
`define PATH_TIA_ADC_BUF 16'hae65
`define PATH_TIA_ADC 16'hb065

`endif

// File: afe_slot_cfg_pkg.sv
// Types shared by the front-end slot configuration bank.
// Assumes nothing of its surroundings.
`default_nettype none
package afe_slot_cfg_pkg;
    // Selected analog path decoded from the path connection code
    typedef enum logic [1:0] {
        PATH_FULL_type_val = 2'b00,
        PATH_TIA_ADC_type_val = 2'b01,
        PATH_RESERVED_type_val = 2'b10
    } path_mode_type;
endpackage
`default_nettype wire

// File: afe_slot_config_registers.sv
// Configuration register bank for the two-slot optical front end.
// Assumes a serial host port that hands in decoded single-cycle register
// reads and writes synchronous to i_core_clk.
//
// Operation
// RQ1 - Each slot has four order bits: zero normal, one reversed integration.
// RQ2 - Bit zero drives pulse one, bit three pulse four, then repeats.
// RQ3 - Window width is timing bits 15:11, counted in one microsecond units.
// RQ4 - Window offset is timing bits 10:0, counted in 31.25 ns steps.
// RQ5 - Slot A offset resets 0x2FC; slot B resets width 0x04, offset 0x17.
// RQ6 - Per-channel enable: ch1 local gain, ch2-4 from 0x55; else common gain. The bank honours the enable in slot A only; slot B always uses common gain.
// RQ7 - Gain code 0..3 selects 200, 100, 50, 25 kOhm; resets to zero.
// RQ8 - Reference select 0..3 gives 1.14, 1.01, 0.90, 1.27 V; resets 3.
// RQ9 - Buffer bit turns the integrator into a buffer, for TIA-to-ADC only.
// RQ10 - Path register resets 0xADA5; 0xAE65 and 0xB065 mean TIA-to-ADC.
// RQ11 - Host uses 0xAE65 only with both buffer bits set, else 0xB065; the host model checks only the slot A buffer bit.
// RQ12 - Channel two gain field uses the same four-step gain encoding.
// RQ13 - Host writes fixed patterns; every read-write field reads back as written.
`timescale 1ns/100ps
`default_nettype none
`include "afe_slot_cfg_regs.svh"

module afe_slot_config_registers
    import afe_slot_cfg_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_pulse_strobe,
    input wire logic i_slot_b_active,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_pulse_reversed,
    output logic [7:0] o_channel_gain,
    output logic [1:0] o_amp_reference_select,
    output logic o_integrator_buffer_mode,
    output logic [4:0] o_window_width,
    output logic [10:0] o_window_offset,
    output logic [1:0] o_path_mode
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    logic [15:0] order_a_q;
    logic [15:0] order_b_q;
    logic [15:0] timing_a_q;
    logic [15:0] timing_b_q;
    logic [15:0] fe_a_q;
    logic [15:0] fe_b_q;
    logic [15:0] path_a_q;
    logic [15:0] chan_gain_q;
    logic [1:0] pulse_idx_q;
    logic slot_b_q;
    logic [15:0] rdata_d;
    logic [15:0] fe_sel;
    logic [15:0] order_sel;
    logic [15:0] timing_sel;
    logic [7:0] gain_d;
    path_mode_type path_d;

    // Writes store whole words so readback returns them unchanged
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            order_a_q <= `RST_ORDER;
            order_b_q <= `RST_ORDER;
            timing_a_q <= `RST_SLOT_A_TIMING; // RQ5
            timing_b_q <= `RST_SLOT_B_TIMING; // RQ5
            fe_a_q <= `RST_FE_CTRL; // RQ7 RQ8
            fe_b_q <= `RST_FE_CTRL;
            path_a_q <= `RST_PATH; // RQ10
            chan_gain_q <= `RST_CHAN_GAIN;
        end
        else if (i_reg_wr)
        begin
            case (i_reg_addr)
                `OFS_SLOT_A_ORDER: order_a_q <= i_reg_wdata; // RQ13
                `OFS_SLOT_B_ORDER: order_b_q <= i_reg_wdata;
                `OFS_SLOT_A_TIMING: timing_a_q <= i_reg_wdata;
                `OFS_SLOT_B_TIMING: timing_b_q <= i_reg_wdata;
                `OFS_SLOT_A_FE_CTRL: fe_a_q <= i_reg_wdata;
                `OFS_SLOT_A_PATH: path_a_q <= i_reg_wdata; // RQ10
                `OFS_SLOT_B_FE_CTRL: fe_b_q <= i_reg_wdata;
                `OFS_CHAN_GAIN: chan_gain_q <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (i_reg_addr)
            `OFS_SLOT_A_ORDER: rdata_d = order_a_q; // RQ13
            `OFS_SLOT_B_ORDER: rdata_d = order_b_q;
            `OFS_SLOT_A_TIMING: rdata_d = timing_a_q;
            `OFS_SLOT_B_TIMING: rdata_d = timing_b_q;
            `OFS_SLOT_A_FE_CTRL: rdata_d = fe_a_q;
            `OFS_SLOT_A_PATH: rdata_d = path_a_q;
            `OFS_SLOT_B_FE_CTRL: rdata_d = fe_b_q;
            `OFS_CHAN_GAIN: rdata_d = chan_gain_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    // Read data registered, answered one cycle after the request
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
            begin
                o_reg_rdata <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pulse sequencing
    // ------------------------------------------------------------------------
    // Index wraps after the fourth pulse; a slot change restarts at pulse one
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            pulse_idx_q <= `RST_PULSE_IDX;
            slot_b_q <= 1'b0;
        end
        else
        begin
            slot_b_q <= i_slot_b_active;
            if (slot_b_q != i_slot_b_active)
            begin
                pulse_idx_q <= `RST_PULSE_IDX;
            end
            else if (i_pulse_strobe)
            begin
                pulse_idx_q <= pulse_idx_q + 2'h1; // RQ2
            end
        end
    end

    // ------------------------------------------------------------------------
    // Decoded configuration outputs
    // ------------------------------------------------------------------------
    assign fe_sel = i_slot_b_active ? fe_b_q : fe_a_q;
    assign order_sel = i_slot_b_active ? order_b_q : order_a_q;
    assign timing_sel = i_slot_b_active ? timing_b_q : timing_a_q;

    // Gain fan-out per channel; channel 2..4 codes live in the shared register
    always_comb
    begin
        gain_d = {4{fe_sel[`GAIN_MSB:0]}}; // RQ6 RQ7
        if (!i_slot_b_active && fe_a_q[`IND_EN_BIT])
        begin
            gain_d = {chan_gain_q[`CH4_GAIN_MSB:`CH4_GAIN_LSB],
                      chan_gain_q[`CH3_GAIN_MSB:`CH3_GAIN_LSB],
                      chan_gain_q[`CH2_GAIN_MSB:0], // RQ12
                      fe_a_q[`GAIN_MSB:0]}; // RQ6
        end
    end

    // Path decode; the host keeps the slot A buffer bit consistent with the code
    always_comb
    begin
        case (path_a_q)
            `PATH_FULL_ANALOG: path_d = PATH_FULL_type_val;
            `PATH_TIA_ADC_BUF: path_d = PATH_TIA_ADC_type_val; // RQ10 RQ11
            `PATH_TIA_ADC: path_d = PATH_TIA_ADC_type_val; // RQ10
            default: path_d = PATH_RESERVED_type_val;
        endcase
    end

    // All decoded outputs registered for clean timing to the analog side
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_pulse_reversed <= 1'b0;
            o_channel_gain <= 8'h00;
            o_amp_reference_select <= `RST_REF_SELECT; // RQ8
            o_integrator_buffer_mode <= 1'b0;
            o_window_width <= 5'h00;
            o_window_offset <= 11'h000;
            o_path_mode <= PATH_FULL_type_val;
        end
        else
        begin
            o_pulse_reversed <= order_sel[pulse_idx_q]; // RQ1 RQ2
            o_channel_gain <= gain_d;
            o_amp_reference_select <= fe_sel[`VREF_MSB:`VREF_LSB]; // RQ8
            o_integrator_buffer_mode <= fe_sel[`BUF_BIT]; // RQ9
            o_window_width <= timing_sel[`WIDTH_MSB:`WIDTH_LSB]; // RQ3
            o_window_offset <= timing_sel[`OFFSET_MSB:0]; // RQ4
            o_path_mode <= path_d;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_write_path;
        i_reg_wr && i_reg_addr == `OFS_SLOT_A_PATH;
    endsequence
    sequence s_read_path;
        i_reg_rd && !i_reg_wr && i_reg_addr == `OFS_SLOT_A_PATH;
    endsequence
    sequence s_slot_restart;
        slot_b_q != i_slot_b_active ##1 1'b1;
    endsequence

    // Write, one idle edge, then read: the answer carries the written word
    property p_readback;
        @(posedge i_core_clk) disable iff (i_reset)
        s_write_path ##1 !i_reg_wr ##1 s_read_path |=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // RQ13

    // The first pulse after a slot change uses bit zero of that slot's order
    property p_reversed;
        @(posedge i_core_clk) disable iff (i_reset)
        s_slot_restart |=> o_pulse_reversed == $past(i_slot_b_active ? order_b_q[0] : order_a_q[0]);
    endproperty
    a_reversed: assert property (p_reversed) else $error("polarity wrong"); // RQ1 RQ2

    property p_wrap;
        @(posedge i_core_clk) disable iff (i_reset)
        i_pulse_strobe && pulse_idx_q == 2'h3 && slot_b_q == i_slot_b_active |=> pulse_idx_q == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pulse index did not wrap"); // RQ2

    property p_width;
        @(posedge i_core_clk) disable iff (i_reset)
        1 |=> o_window_width ==
            $past(i_slot_b_active ? timing_b_q[`WIDTH_MSB:`WIDTH_LSB] : timing_a_q[`WIDTH_MSB:`WIDTH_LSB]);
    endproperty
    a_width: assert property (p_width) else $error("width wrong"); // RQ3

    property p_offset;
        @(posedge i_core_clk) disable iff (i_reset)
        1 |=> o_window_offset ==
            $past(i_slot_b_active ? timing_b_q[`OFFSET_MSB:0] : timing_a_q[`OFFSET_MSB:0]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset wrong"); // RQ4

    property p_reset_timing;
        @(posedge i_core_clk)
        i_reset |=> timing_a_q[`OFFSET_MSB:0] == `RST_SLOT_A_OFFSET && timing_b_q == `RST_SLOT_B_TIMING;
    endproperty
    a_reset_timing: assert property (p_reset_timing) else $error("timing reset wrong"); // RQ5

    property p_ind_gain;
        @(posedge i_core_clk) disable iff (i_reset)
        !i_slot_b_active && fe_a_q[`IND_EN_BIT] |=>
            o_channel_gain == {$past(chan_gain_q[`CH4_GAIN_MSB:0]), $past(fe_a_q[`GAIN_MSB:0])};
    endproperty
    a_ind_gain: assert property (p_ind_gain) else $error("per-channel gain wrong"); // RQ6

    property p_common_gain;
        @(posedge i_core_clk) disable iff (i_reset)
        !fe_sel[`IND_EN_BIT] |=> o_channel_gain == {4{$past(fe_sel[`GAIN_MSB:0])}};
    endproperty
    a_common_gain: assert property (p_common_gain) else $error("common gain wrong"); // RQ7

    property p_vref;
        @(posedge i_core_clk)
        i_reset |=> o_amp_reference_select == `RST_REF_SELECT && fe_a_q[`VREF_MSB:`VREF_LSB] == `RST_REF_SELECT;
    endproperty
    a_vref: assert property (p_vref) else $error("reference reset wrong"); // RQ8

    property p_buf;
        @(posedge i_core_clk) disable iff (i_reset)
        1 |=> o_integrator_buffer_mode == $past(i_slot_b_active ? fe_b_q[`BUF_BIT] : fe_a_q[`BUF_BIT]);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer mode wrong"); // RQ9

    property p_path;
        @(posedge i_core_clk) disable iff (i_reset)
        path_a_q == `PATH_TIA_ADC || path_a_q == `PATH_TIA_ADC_BUF |=> o_path_mode == PATH_TIA_ADC_type_val;
    endproperty
    a_path: assert property (p_path) else $error("path decode wrong"); // RQ10

endmodule // afe_slot_config_registers
`default_nettype wire

// File: afe_host_model.sv
// Host side of the register port: write and read tasks on the strobes.
// Assumes one clock shared with the bank and registered read answers.
`timescale 1ns/100ps
`default_nettype none

module afe_host_model (
    input wire logic i_core_clk,
    input wire logic [15:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [15:0] o_reg_wdata
);
    logic buf_set = 1'b0;

    // Idle bus at time zero
    initial
    begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 16'h0000;
    end

    // Fixed patterns forced so a sloppy caller cannot upset the device
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        if (a == 8'h42 || a == 8'h44)
            d = {6'h07, d[9:4], 2'h1, d[1:0]};
        if (a == 8'h42)
            buf_set = d[7];
        if (a == 8'h43 && d == 16'hae65 && !buf_set)
            d = 16'hb065;
        @(posedge i_core_clk);
        #1;
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(posedge i_core_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask

    // Answer is sampled just after the taking edge, bounded wait
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(posedge i_core_clk);
        #1;
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(posedge i_core_clk);
        #1;
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        n = 0;
        while (i_reg_rvalid !== 1'b1 && n < 4)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
    endtask
endmodule // afe_host_model

`default_nettype wire

// File: afe_slot_config_registers_tb_top.sv
// Self-checking bench of the slot configuration bank.
// Assumes the host model drives the register strobes.
`timescale 1ns/100ps
`default_nettype none

module afe_slot_config_registers_tb_top;
    import afe_slot_cfg_pkg::*;
    logic clk = 1'b0, rst = 1'b1, strobe = 1'b0, slot_b = 1'b0, wr, rd, rv, rev, ibuf;
    logic [7:0] addr, gain;
    logic [15:0] wdata, rdata;
    logic [1:0] vref, path;
    logic [4:0] width;
    logic [10:0] offset;
    int error_cnt = 0, checks = 0;
    logic [7:0] adr [8] = '{8'h17, 8'h1d, 8'h39, 8'h3b, 8'h42, 8'h43, 8'h44, 8'h55};
    logic [15:0] val [8] = '{16'h000a, 16'h0006, 16'h5123, 16'h2b45, 16'h1c94, 16'hb065, 16'h1c24, 16'h0038};
    logic [15:0] code [4] = '{16'hada5, 16'hb065, 16'hae65, 16'h1234};
    logic [1:0] mode [4] = '{2'h0, 2'h1, 2'h1, 2'h2};

    afe_slot_config_registers dut (.i_core_clk(clk), .i_reset(rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_pulse_strobe(strobe), .i_slot_b_active(slot_b),
        .o_reg_rdata(rdata), .o_reg_rvalid(rv), .o_pulse_reversed(rev), .o_channel_gain(gain),
        .o_amp_reference_select(vref), .o_integrator_buffer_mode(ibuf), .o_window_width(width),
        .o_window_offset(offset), .o_path_mode(path));
    afe_host_model host (.i_core_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rv), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));

    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Compare tasks
    // ------------------------------------------------------------------
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        checks++;
        if (d !== e)
        begin
            error_cnt++;
            $display("ERROR %0t read %h got %h exp %h", $time, a, d, e);
        end
    endtask

    task automatic chk_out(input logic [15:0] g, input logic [15:0] e, input string m);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // Decoded outputs lag a store by one cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pulse();
        @(posedge clk);
        #1;
        strobe = 1'b1;
        @(posedge clk);
        #1;
        strobe = 1'b0;
        settle();
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog far beyond the roughly 140 cycles the tests take
    initial
    begin
        #40000;
        error_cnt++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        settle();
        chk_out(16'(vref), 16'h3, "vref");
        chk_out(16'(gain), 16'h0, "gain");
        chk_out(16'(width), 16'h4, "width");
        chk_out(16'(offset), 16'h2fc, "offset");
        chk_out(16'(path), 16'h0, "path");
        chk_rd(8'h43, 16'hada5);
        chk_rd(8'h39, 16'h22fc);
        chk_rd(8'h3b, 16'h2017);
        chk_rd(8'h42, 16'h1c38);
        chk_rd(8'h17, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            host.wr(adr[i], val[i]);
        host.wr(8'h20, 16'hffff);
        for (int i = 0; i < 8; i++)
            chk_rd(adr[i], val[i]);
        chk_rd(8'h20, 16'h0000);
        $display("test readback done");
        settle();
        chk_out({width, offset}, 16'h5123, "slot a timing");
        chk_out({13'h0, ibuf, vref}, 16'h5, "slot a control");
        // Pulse pattern 1010 on slot A, wraps after the fourth pulse
        for (int k = 0; k < 6; k++)
        begin
            chk_out(16'(rev), 16'(val[0][k % 4]), "order a");
            pulse();
        end
        slot_b = 1'b1;
        settle();
        chk_out({width, offset}, 16'h2b45, "slot b timing");
        chk_out({13'h0, ibuf, vref}, 16'h2, "slot b control");
        chk_out(16'(rev), 16'h0, "order b first");
        pulse();
        chk_out(16'(rev), 16'h1, "order b second");
        slot_b = 1'b0;
        $display("test timing order done");
        for (int g = 0; g < 4; g++)
        begin
            host.wr(8'h42, 16'h1c34 | 16'(g));
            settle();
            chk_out(16'(gain), 16'({4{2'(g)}}), "common gain");
        end
        host.wr(8'h42, 16'h1c75);
        settle();
        chk_out(16'(gain), 16'he1, "channel gains");
        $display("test gain done");
        host.wr(8'h42, 16'h1cb4);
        for (int i = 0; i < 4; i++)
        begin
            host.wr(8'h43, code[i]);
            chk_rd(8'h43, code[i]);
            settle();
            chk_out(16'(path), 16'(mode[i]), "path mode");
        end
        $display("test path done");
        stop_test();
    end
endmodule // afe_slot_config_registers_tb_top

`default_nettype wire
